/* File: verilog/lcd_refresh_pkg.sv */
// Constants shared by the LCD refresh engine and its word buffer.
// Assumes a 200 MHz system clock and a fixed 128 x 128 monochrome panel.
package lcd_refresh_pkg;

   // ==========================================================================
   // Raster and frame buffer
   localparam int          WORD_W       = 32;
   localparam int          NIB_W        = 4;
   localparam int          FB_WORDS     = 512;
   localparam int          FB_IDX_W     = 9;
   localparam int          ROW_PIXELS   = 128;
   localparam int          ROW_COUNT    = 128;
   localparam logic [4:0]  LAST_NIB_COL = 5'h1f;
   localparam logic [6:0]  LAST_ROW     = 7'h7f;
   localparam logic [2:0]  LAST_NIB     = 3'h7;
   localparam logic [31:0] FB_BASE      = 32'h0000_0000;

   // ==========================================================================
   // Fetch and buffering
   localparam int          REFRESH_DEPTH = 3;
   localparam int          SKID_DEPTH    = 2;
   localparam int          BURST_WORDS   = 2;
   localparam logic [1:0]  ROOM_LEVEL    = 2'h1;

   // ==========================================================================
   // Timing: one column shift slot of at most 16 MHz.
   localparam int          CLK_PERIOD_PS   = 5000;
   localparam int          SHIFT_PERIOD_PS = 62500;
   localparam int          SHIFT_CYC       = (SHIFT_PERIOD_PS + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
   localparam logic [3:0]  SHIFT_LAST      = 4'(SHIFT_CYC - 1);
   localparam logic [3:0]  SHIFT_HALF      = 4'(SHIFT_CYC / 2);

   // ==========================================================================
   // Fetch state machine, Gray coded along idle -> request -> transfer.
   typedef enum logic [1:0]
   {
      FETCH_IDLE = 2'h0,
      FETCH_REQ  = 2'h1,
      FETCH_XFER = 2'h3
   } fetch_state_type;

endpackage

/* File: verilog/word_fifo.sv */
// Small register-based FIFO with valid/ready on both sides.
// Assumes both sides run on the system clock; data sits in flip-flops.
module word_fifo
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 3
)
(
   // Clock and reset
   input  wire logic                       clk_sys_in,
   input  wire logic                       rstn_in,
   // Fill side
   input  wire logic                       in_valid_in,
   output wire logic                       in_ready_out,
   input  wire logic [WIDTH-1:0]           in_data_in,
   // Drain side
   output wire logic                       out_valid_out,
   input  wire logic                       out_ready_in,
   output wire logic [WIDTH-1:0]           out_data_out,
   // Fill level
   output wire logic [$clog2(DEPTH+1)-1:0] level_out
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW-1:0]    wr_ptr_ff;
   logic [PW-1:0]    rd_ptr_ff;
   logic [CW-1:0]    count_ff;
   wire              push;
   wire              pop;
   wire  [PW-1:0]    nxt_wr_ptr;
   wire  [PW-1:0]    nxt_rd_ptr;

   assign in_ready_out  = (count_ff != CW'(DEPTH));
   assign out_valid_out = (count_ff != '0);
   assign out_data_out  = mem_ff[rd_ptr_ff];
   assign level_out     = count_ff;
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;
   assign nxt_wr_ptr    = (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
   assign nxt_rd_ptr    = (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;

   always_ff @(posedge clk_sys_in)
   begin
      if (push)
      begin
         mem_ff[wr_ptr_ff] <= in_data_in;
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!rstn_in)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_ff <= nxt_wr_ptr;
         end
         if (pop)
         begin
            rd_ptr_ff <= nxt_rd_ptr;
         end
         count_ff <= count_ff + CW'(push) - CW'(pop);
      end
   end

endmodule // word_fifo

/* File: verilog/lcd_refresh_controller.sv */
// LCD refresh engine: fetches the frame buffer over the module bus and
// streams it to the column and row driver chips.
// Assumes the module bus, the CPU request and the driver chips share clk_sys_in.
//
// Behaviour
// - fixed 128 x 128 raster, nothing programmable
// - bus master, fetches without CPU help
// - fetched words enter FIFO by burst
// - shift whole words out, four bits per column shift clock
// - next word loaded when shift register empties, unless a line latch is due or no word is buffered
// - every fetch is exactly two consecutive words
// - three-word FIFO, fetch about every microsecond
// - frame buffer is 512 words of 32 pixels
// - word MSB is leftmost pixel
// - four column data lines plus shift clock
// - scan start, row clock, latch, frame outputs
// - rotating arbiter between CPU and refresh
module lcd_refresh_controller
(
   // Clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rstn_in,
   // Module bus arbitration
   input  wire logic        cpu_req_in,
   output wire logic        cpu_gnt_out,
   // Module bus read master
   output wire logic        bus_rd_out,
   output wire logic [31:0] bus_addr_out,
   input  wire logic        bus_ack_in,
   input  wire logic [31:0] bus_data_in,
   // Column driver
   output wire logic [3:0]  col_drv_data_out,
   output wire logic        col_drv_shift_clk_out,
   // Row driver and panel
   output wire logic        line_latch_pulse_out,
   output wire logic        row_drv_shift_clk_out,
   output wire logic        row_scan_start_out,
   output wire logic        frame_signal_out
);
   import lcd_refresh_pkg::*;

   // =========================================================================
   // Arbiter and fetch state
   fetch_state_type              state_ff;
   fetch_state_type              nxt_state;
   logic                         cpu_own_ff;
   logic                         lcd_own_ff;
   logic                         last_lcd_ff;
   logic                         beat_ff;
   logic [FB_IDX_W-1:0]          idx_ff;
   wire                          lcd_req;
   wire                          bus_free;
   wire                          pick_lcd;
   wire                          pick_cpu;
   wire                          burst_done;
   wire                          room;
   wire  [1:0]                   refresh_level;
   wire                          refresh_in_ready;
   wire                          word_taken;

   // A fresh burst is asked for the moment two words fit, hiding grant latency.
   assign room       = (refresh_level <= ROOM_LEVEL);
   assign lcd_req    = (state_ff == FETCH_REQ);
   assign bus_free   = !cpu_own_ff && !lcd_own_ff;
   assign pick_lcd   = bus_free && lcd_req && (!cpu_req_in || !last_lcd_ff);
   assign pick_cpu   = bus_free && cpu_req_in && !pick_lcd;
   assign word_taken = (state_ff == FETCH_XFER) && bus_ack_in;
   assign burst_done = word_taken && beat_ff;
   assign cpu_gnt_out  = cpu_own_ff;
   assign bus_rd_out   = (state_ff == FETCH_XFER);
   assign bus_addr_out = FB_BASE + {21'h0, idx_ff, 2'h0};

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         FETCH_IDLE: if (room) nxt_state = FETCH_REQ;
         FETCH_REQ:  if (lcd_own_ff) nxt_state = FETCH_XFER;
         FETCH_XFER: if (burst_done) nxt_state = FETCH_IDLE;
         default:    nxt_state = FETCH_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!rstn_in)
      begin
         state_ff    <= FETCH_IDLE;
         cpu_own_ff  <= 1'b0;
         lcd_own_ff  <= 1'b0;
         last_lcd_ff <= 1'b0;
         beat_ff     <= 1'b0;
         idx_ff      <= '0;
      end
      else
      begin
         state_ff   <= nxt_state;
         cpu_own_ff <= pick_cpu || (cpu_own_ff && cpu_req_in);
         lcd_own_ff <= pick_lcd || (lcd_own_ff && !burst_done);
         if (pick_lcd || pick_cpu)
         begin
            last_lcd_ff <= pick_lcd;
         end
         if (word_taken)
         begin
            beat_ff <= !beat_ff;
            idx_ff  <= idx_ff + 1'b1;
         end
      end
   end

   // =========================================================================
   // Word buffers: refresh FIFO then a two-entry skid buffer to the shifter.
   wire              mid_valid;
   wire              mid_ready;
   wire  [31:0]      mid_data;
   wire              word_valid;
   wire              word_ready;
   wire  [31:0]      word_data;

   word_fifo #(.WIDTH(WORD_W), .DEPTH(REFRESH_DEPTH)) refresh_fifo
   (
      .clk_sys_in    (clk_sys_in),
      .rstn_in       (rstn_in),
      .in_valid_in   (word_taken),
      .in_ready_out  (refresh_in_ready),
      .in_data_in    (bus_data_in),
      .out_valid_out (mid_valid),
      .out_ready_in  (mid_ready),
      .out_data_out  (mid_data),
      .level_out     (refresh_level)
   );

   word_fifo #(.WIDTH(WORD_W), .DEPTH(SKID_DEPTH)) skid_fifo
   (
      .clk_sys_in    (clk_sys_in),
      .rstn_in       (rstn_in),
      .in_valid_in   (mid_valid),
      .in_ready_out  (mid_ready),
      .in_data_in    (mid_data),
      .out_valid_out (word_valid),
      .out_ready_in  (word_ready),
      .out_data_out  (word_data),
      .level_out     ()
   );

   // =========================================================================
   // Shift engine. Each slot is SHIFT_CYC clocks; a slot either sends one
   // nibble or, after 32 nibbles, pulses the line latch. If no word is there
   // the slot idles, so a starved bus stalls the picture instead of tearing it.
   logic [3:0]  phase_ff;
   logic [31:0] shreg_ff;
   logic [2:0]  nib_left_ff;
   logic [4:0]  col_ff;
   logic [6:0]  row_ff;
   logic        line_end_ff;
   logic        active_ff;
   logic        latch_ff;
   logic        scan_ff;
   logic        frame_ff;
   logic [3:0]  data_ff;
   wire         tick;
   wire         shifting;
   wire         do_latch;
   wire         do_load;

   assign tick       = (phase_ff == SHIFT_LAST);
   assign shifting   = tick && (nib_left_ff != 3'h0);
   assign do_latch   = tick && (nib_left_ff == 3'h0) && line_end_ff;
   assign word_ready = tick && (nib_left_ff == 3'h0) && !line_end_ff;
   assign do_load    = word_ready && word_valid;
   assign col_drv_data_out      = data_ff;
   assign col_drv_shift_clk_out = active_ff && (phase_ff >= SHIFT_HALF);
   assign line_latch_pulse_out  = latch_ff;
   assign row_drv_shift_clk_out = latch_ff;
   assign row_scan_start_out    = scan_ff;
   assign frame_signal_out      = frame_ff;

   always_ff @(posedge clk_sys_in)
   begin
      if (!rstn_in)
      begin
         phase_ff    <= '0;
         shreg_ff    <= '0;
         nib_left_ff <= '0;
         col_ff      <= '0;
         row_ff      <= '0;
         line_end_ff <= 1'b0;
         active_ff   <= 1'b0;
         latch_ff    <= 1'b0;
         scan_ff     <= 1'b0;
         frame_ff    <= 1'b0;
         data_ff     <= '0;
      end
      else
      begin
         phase_ff <= tick ? 4'h0 : phase_ff + 1'b1;
         if (tick)
         begin
            active_ff <= shifting || do_load;
            latch_ff  <= do_latch;
            scan_ff   <= do_latch && (row_ff == LAST_ROW);
         end
         if (do_load)
         begin
            data_ff     <= word_data[31:28];
            shreg_ff    <= {word_data[27:0], 4'h0};
            nib_left_ff <= LAST_NIB;
         end
         else if (shifting)
         begin
            data_ff     <= shreg_ff[31:28];
            shreg_ff    <= {shreg_ff[27:0], 4'h0};
            nib_left_ff <= nib_left_ff - 1'b1;
         end
         if (do_load || shifting)
         begin
            col_ff <= col_ff + 1'b1;
            if (col_ff == LAST_NIB_COL)
            begin
               line_end_ff <= 1'b1;
            end
         end
         if (do_latch)
         begin
            line_end_ff <= 1'b0;
            row_ff      <= row_ff + 1'b1;
            if (row_ff == LAST_ROW)
            begin
               frame_ff <= !frame_ff;
            end
         end
      end
   end

   // =========================================================================
   // Checks
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);

   burst_two_words_a: assert property (word_taken && !beat_ff
      |=> bus_rd_out && (bus_addr_out == $past(bus_addr_out) + 32'h4))
      else $error("Burst did not continue with the next word.");
   fifo_no_overflow_a: assert property (bus_rd_out && bus_ack_in |-> refresh_in_ready)
      else $error("Fetched word arrived with the refresh FIFO full.");
   request_on_room_a: assert property ((state_ff == FETCH_IDLE) && room |=> lcd_req)
      else $error("Burst not requested although two words fit.");
   grant_exclusive_a: assert property (!(cpu_own_ff && lcd_own_ff))
      else $error("Bus granted to both masters.");
   cpu_holds_bus_a: assert property (cpu_own_ff && cpu_req_in |=> !lcd_own_ff)
      else $error("Refresh took the bus from the CPU.");
   col_clock_high_a: assert property ($rose(col_drv_shift_clk_out)
      |-> col_drv_shift_clk_out [*7] ##1 !col_drv_shift_clk_out)
      else $error("Column shift clock high time wrong.");
   msb_first_a: assert property (do_load
      |=> col_drv_data_out == $past(word_data[31:28]))
      else $error("First nibble is not the word's top bits.");
   latch_row_clock_a: assert property ($rose(line_latch_pulse_out)
      |-> row_drv_shift_clk_out && $past(col_ff) == 5'h0)
      else $error("Latch not at a line boundary.");
   scan_start_a: assert property (row_scan_start_out
      |-> line_latch_pulse_out && row_ff == 7'h0)
      else $error("Scan start outside the first row latch.");

endmodule // lcd_refresh_controller

/* File: tb/lcd_tb_pkg.sv */
// Bench helpers: the frame-buffer contents that the memory responder serves.
// Assumes only a 32-bit module bus and a 512-word frame buffer.
package lcd_tb_pkg;

   // ==========================================================================
   // Frame-buffer word at an index, scrambled by a per-run salt.
   function automatic logic [31:0] fb_word(input logic [8:0] idx, input logic [31:0] salt);
      return {idx, 23'h0} ^ (salt * {23'h0, idx}) ^ salt;
   endfunction

endpackage

/* File: tb/lcd_panel_model.sv */
// Column and row driver model: captures each nibble and checks the panel timing.
// Assumes the driver pins change on rising clk_sys_in edges, so it samples on falling ones.
module lcd_panel_model
(
   // Clock and picture salt
   input  wire logic        clk_sys_in,
   input  wire logic [31:0] salt_in,
   // Driver pins
   input  wire logic [3:0]  col_drv_data_in,
   input  wire logic        col_drv_shift_clk_in,
   input  wire logic        line_latch_pulse_in,
   input  wire logic        row_drv_shift_clk_in,
   input  wire logic        row_scan_start_in,
   input  wire logic        frame_signal_in,
   // Tallies
   output int               n_errors_out,
   output int               checks_out,
   output int               frames_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import lcd_tb_pkg::*;

   logic [11:0] nib;
   logic [31:0] w;
   int          col;
   int          row;
   int          gap;
   logic        clk_d;
   logic        lat_d;
   logic        lat_dd;
   logic        frame_exp;
   logic        started;

   initial
   begin
      {n_errors_out, checks_out, frames_out, col, row, gap} = '0;
      {nib, clk_d, lat_d, lat_dd, frame_exp, started} = '0;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_out++;
      if (got !== exp)
      begin
         n_errors_out++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   // ==========================================================================
   // Sampling on the falling edge keeps the model clear of the design's updates.
   always @(negedge clk_sys_in)
   begin
      gap = gap + 1;
      check("row clock", {31'h0, line_latch_pulse_in}, {31'h0, row_drv_shift_clk_in});
      if (col_drv_shift_clk_in && !clk_d)
      begin
         if (started) check("slot spacing", (col == 0) ? 32'd26 : 32'd13, gap);
         check("frame signal", {31'h0, frame_exp}, {31'h0, frame_signal_in});
         w = fb_word(nib[11:3], salt_in) << (4 * nib[2:0]);
         check("pixel nibble", {28'h0, w[31:28]}, {28'h0, col_drv_data_in});
         nib = nib + 1;
         col = col + 1;
         gap = 0;
         started = 1'b1;
      end
      if (line_latch_pulse_in && lat_d && !lat_dd)
      begin
         check("nibbles per row", 32'd32, col);
         check("scan start", {31'h0, row == 127}, {31'h0, row_scan_start_in});
         if (row == 127)
         begin
            frame_exp = !frame_exp;
            frames_out++;
         end
         row = (row + 1) % 128;
         col = 0;
      end
      lat_dd = lat_d;
      lat_d = line_latch_pulse_in;
      clk_d = col_drv_shift_clk_in;
   end

endmodule // lcd_panel_model

/* File: tb/lcd_refresh_controller_tb.sv */
// Testbench for the LCD refresh engine: memory responder, CPU requester, panel model.
// Assumes the design and bench share one 200 MHz clock; inputs change on falling edges.
module lcd_refresh_controller_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import lcd_tb_pkg::*;

   logic        clk_sys_in = 1'b0;
   logic        rstn_in = 1'b0;
   logic        cpu_req_in = 1'b0;
   logic        bus_ack_in = 1'b0;
   logic [31:0] bus_data_in = 32'h0;
   wire  logic  cpu_gnt_out;
   wire  logic  bus_rd_out;
   wire  logic [31:0] bus_addr_out;
   wire  logic [3:0]  col_drv_data_out;
   wire  logic  col_drv_shift_clk_out;
   wire  logic  line_latch_pulse_out;
   wire  logic  row_drv_shift_clk_out;
   wire  logic  row_scan_start_out;
   wire  logic  frame_signal_out;
   int          n_errors = 0;
   int          checks = 0;
   int          m_err;
   int          m_chk;
   int          frames;
   int          acks = 0;
   int          bursts = 0;
   int          lat = 0;
   int          hold = 0;
   int          idle = 30;
   int          waited = 0;
   logic        req_last = 1'b0;
   logic        req_prev = 1'b0;
   logic [8:0]  exp_idx = 9'h0;
   logic [31:0] seed = 32'd21857;
   logic [31:0] salt;

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic summarize();
      n_errors += m_err;
      checks += m_chk;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   lcd_refresh_controller lcd_refresh_controller_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
      .cpu_req_in(cpu_req_in), .cpu_gnt_out(cpu_gnt_out), .bus_rd_out(bus_rd_out),
      .bus_addr_out(bus_addr_out), .bus_ack_in(bus_ack_in), .bus_data_in(bus_data_in),
      .col_drv_data_out(col_drv_data_out), .col_drv_shift_clk_out(col_drv_shift_clk_out),
      .line_latch_pulse_out(line_latch_pulse_out), .row_drv_shift_clk_out(row_drv_shift_clk_out),
      .row_scan_start_out(row_scan_start_out), .frame_signal_out(frame_signal_out));

   lcd_panel_model lcd_panel_model_i (.clk_sys_in(clk_sys_in), .salt_in(salt),
      .col_drv_data_in(col_drv_data_out), .col_drv_shift_clk_in(col_drv_shift_clk_out),
      .line_latch_pulse_in(line_latch_pulse_out), .row_drv_shift_clk_in(row_drv_shift_clk_out),
      .row_scan_start_in(row_scan_start_out), .frame_signal_in(frame_signal_out),
      .n_errors_out(m_err), .checks_out(m_chk), .frames_out(frames));

   initial
   begin
      salt = xorshift(seed);
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end

   // ==========================================================================
   // Memory responder and CPU requester; random ack latency of 0 to 3 cycles.
   always @(negedge clk_sys_in)
   begin
      seed = xorshift(seed);
      bus_ack_in = 1'b0;
      bus_data_in = seed;
      check("bus exclusive", 32'h0, {31'h0, bus_rd_out & cpu_gnt_out});
      if (bus_rd_out === 1'b1)
      begin
         if (lat > 0)
            lat = lat - 1;
         else
         begin
            check("fetch address", {21'h0, exp_idx, 2'h0}, bus_addr_out);
            bus_data_in = fb_word(exp_idx, salt);
            bus_ack_in = 1'b1;
            exp_idx = exp_idx + 9'h1;
            acks++;
            lat = int'(seed[1:0]);
         end
      end
      else if (acks != 0)
      begin
         check("words per burst", 32'd2, acks);
         acks = 0;
         bursts++;
      end
      req_prev = req_last;
      req_last = cpu_req_in;
      if (!req_prev && !req_last) check("idle grant", 32'h0, {31'h0, cpu_gnt_out});
      if (cpu_req_in && cpu_gnt_out === 1'b1)
      begin
         if (waited >= 0) check("grant wait", 32'h1, {31'h0, waited <= 30});
         waited = -1;
         if (hold == 0)
         begin
            cpu_req_in = 1'b0;
            idle = 10 + int'(seed[5:0]);
         end
         else
            hold = hold - 1;
      end
      else if (cpu_req_in)
         waited++;
      else if (rstn_in && idle > 0)
         idle = idle - 1;
      else if (rstn_in)
      begin
         cpu_req_in = 1'b1;
         hold = int'(seed[8:6]);
         waited = 0;
      end
   end

   initial
   begin
      repeat (70000) @(posedge clk_sys_in);
      n_errors++;
      $display("unexpected timeout: expected run end seen none");
      summarize();
   end

   initial
   begin
      repeat (12) @(negedge clk_sys_in);
      rstn_in = 1'b1;
      repeat (57000) @(negedge clk_sys_in);
      check("frames shown", 32'h1, {31'h0, frames >= 1});
      check("frame fetched", 32'h1, {31'h0, bursts >= 256});
      summarize();
   end

endmodule // lcd_refresh_controller_tb
